//--- rtl/cpct_timer.sv
// Configurable 16-bit timer with prescaler, auto-reload, up to four channels and APB registers.
// Assumes a peer timer on the same clock drives trig_in and that ch_in comes from pins.
//
// Operation
// (R01) A 16-bit counter is stepped through a prescaler dividing by any value from 1 to 65536.
// (R02) Full variants reload from a programmable value and count up, down or up and down.
// (R03) Full variants have four channels for capture, compare, PWM or one-pulse output.
// (R04) PWM works edge-aligned or center-aligned according to the counting mode.
// (R05) The advanced variant drives complementary pairs separated by a programmable dead-time.
// (R06) The advanced variant spreads three-phase PWM over six outputs.
// (R07) The advanced variant reaches every duty cycle from fully off to fully on.
// (R08) During debug halt the advanced variant can hold its counter and force outputs inactive.
// (R09) General-purpose variants can stop their counter during debug halt.
// (R10) Timers exchange triggers over a link and the peer supplies the trigger it drives.
// (R11) Full variants and the basic variant raise their own DMA requests and the two- and one-channel ones raise none.
// (R12) Full general-purpose variants decode quadrature encoders and one to three hall sensors.
// (R13) Reduced variants count up only and offer two or one channels or a plain time base.
// (R14) Reduced variants take triggers from and give triggers to the full timers.
// (R15) The basic variant has no channels and its update events trigger the converter.
// (R16) Each reload or overflow raises an update event and sets a clearable status flag.
// (R17) A capture edge latches the counter into the channel register and sets its flag.
`include "cpct_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module cpct_timer
#(
    parameter cpct_pkg::cpct_variant_t VARIANT = cpct_pkg::CPCT_ADVANCED
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] ch_in,
    input wire logic trig_in,
    input wire logic dbg_halt,
    output logic [3:0] ch_out,
    output logic [3:0] ch_out_n,
    output logic trig_out,
    output logic dma_req,
    output logic irq
);
    import cpct_pkg::*;

    // ****************************************************************
    // Variant features
    // ****************************************************************
    localparam bit IS_ADV = (VARIANT == CPCT_ADVANCED);
    localparam bit IS_FULL = IS_ADV || (VARIANT == CPCT_FULL_GP);
    localparam bit HAS_DMA = IS_FULL || (VARIANT == CPCT_BASIC);
    localparam int NCH = IS_FULL ? 4 : (VARIANT == CPCT_DUAL_CH) ? 2
        : (VARIANT == CPCT_SINGLE_CH) ? 1 : 0;

    logic [`CPCT_CTRL_W-1:0] ctrl;
    logic [`CPCT_STAT_W-1:0] status;
    logic [`CPCT_STAT_W-1:0] mask;
    logic [15:0] psc;
    logic [15:0] psc_cnt;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic [15:0] chmode;
    logic [7:0] deadtime;
    logic [15:0] ccr [4];
    logic cnt_dir_up;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin;
    logic [3:0] pin_q;
    logic trig_q;
    logic [31:0] rd_val;
    logic rd_hit;
    logic bus_wr;
    logic [3:0] ch_set;

    cpct_cmode_t cmode;
    cpct_smode_t smode;
    cpct_imode_t imode;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign pready = clk_en;
    assign bus_wr = psel && penable && pwrite && clk_en;
    assign pslverr = psel && penable && !rd_hit;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `CPCT_ADDR_CTRL)
            rd_val = {21'h00_0000, ctrl};
        else if (paddr == `CPCT_ADDR_STATUS)
            rd_val = {26'h000_0000, status};
        else if (paddr == `CPCT_ADDR_MASK)
            rd_val = {26'h000_0000, mask};
        else if (paddr == `CPCT_ADDR_PSC)
            rd_val = {16'h0000, psc};
        else if (paddr == `CPCT_ADDR_RELOAD)
            rd_val = {16'h0000, reload};
        else if (paddr == `CPCT_ADDR_COUNT)
            rd_val = {16'h0000, cnt};
        else if (paddr == `CPCT_ADDR_CHMODE)
            rd_val = {16'h0000, chmode};
        else if (paddr == `CPCT_ADDR_DEADTIME)
            rd_val = {24'h00_0000, deadtime};
        else if (paddr >= `CPCT_ADDR_CCR0 && paddr <= `CPCT_ADDR_CCR3 && paddr[1:0] == 2'b00)
            rd_val = {16'h0000, ccr[paddr[3:2]]};
        else
            rd_hit = 1'b0;
    end

    // Read data is caught in the setup cycle and shown through the access phase.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable)
            prdata <= rd_val;
    end

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
            pin <= 4'h0;
            pin_q <= 4'h0;
            trig_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1 <= ch_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pin <= (pin & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
            pin_q <= pin;
            trig_q <= trig_in;
        end
    end

    // ****************************************************************
    // Counting control
    // ****************************************************************
    logic freeze;
    logic run;
    logic trig_ev;
    logic trig_reset;
    logic psc_tick;
    logic enc_edge;
    logic enc_up;
    logic hall_ev;
    logic step;
    logic step_up;
    logic wrap;

    assign cmode = IS_FULL ? cpct_cmode_t'(ctrl[`CPCT_CTRL_CMODE +: 2]) : CPCT_CNT_UP; // R13
    assign smode = cpct_smode_t'(ctrl[`CPCT_CTRL_SMODE +: 2]);
    assign imode = IS_FULL ? cpct_imode_t'(ctrl[`CPCT_CTRL_IMODE +: 2]) : CPCT_IN_INTERNAL;
    assign freeze = dbg_halt && ctrl[`CPCT_CTRL_DBGFREEZE]; // R08 R09
    assign trig_ev = trig_in && !trig_q; // R10 R14
    assign trig_reset = trig_ev && (smode == CPCT_SLV_RESET);
    assign run = ctrl[`CPCT_CTRL_EN] && !freeze
        && !(smode == CPCT_SLV_GATE && !trig_in);
    assign psc_tick = run && (psc_cnt == psc); // R01
    assign enc_edge = ((pin[0] ^ pin_q[0]) || (pin[1] ^ pin_q[1]));
    assign enc_up = pin[0] ^ pin_q[1];
    assign hall_ev = (imode == CPCT_IN_HALL) && (pin[2:0] != pin_q[2:0]); // R12
    assign step = (imode == CPCT_IN_ENCODER) ? (run && enc_edge) : psc_tick; // R12
    assign step_up = (imode == CPCT_IN_ENCODER) ? enc_up
        : (cmode == CPCT_CNT_DOWN) ? 1'b0 : (cmode == CPCT_CNT_CENTER) ? cnt_dir_up : 1'b1;
    assign wrap = step && !trig_reset && (step_up ? (cnt >= reload) : (cnt == 16'h0000)); // R16

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            psc_cnt <= 16'h0000;
        else if (clk_en)
        begin
            if (trig_reset || psc_tick)
                psc_cnt <= 16'h0000; // R01
            else if (run)
                psc_cnt <= psc_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= 16'h0000;
            cnt_dir_up <= 1'b1;
        end
        else if (clk_en)
        begin
            if (trig_reset)
                cnt <= 16'h0000; // R10
            else if (bus_wr && paddr == `CPCT_ADDR_COUNT)
                cnt <= pwdata[15:0];
            else if (wrap && cmode == CPCT_CNT_CENTER && imode != CPCT_IN_ENCODER)
            begin
                cnt_dir_up <= !step_up; // R04
                cnt <= step_up ? cnt - 16'h0001 : cnt + 16'h0001;
            end
            else if (wrap)
                cnt <= step_up ? 16'h0000 : reload; // R02
            else if (step)
                cnt <= step_up ? cnt + 16'h0001 : cnt - 16'h0001;
            if (cmode != CPCT_CNT_CENTER)
                cnt_dir_up <= 1'b1;
        end
    end

    // ****************************************************************
    // Registers written by software
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= `CPCT_RST_CTRL;
            mask <= '0;
            psc <= `CPCT_RST_PSC;
            reload <= `CPCT_RST_RELOAD;
            chmode <= `CPCT_RST_CHMODE;
            deadtime <= `CPCT_RST_DEADTIME;
        end
        else if (clk_en)
        begin
            if (bus_wr && paddr == `CPCT_ADDR_CTRL)
                ctrl <= pwdata[`CPCT_CTRL_W-1:0];
            else if (wrap && ctrl[`CPCT_CTRL_ONEPULSE])
                ctrl[`CPCT_CTRL_EN] <= 1'b0; // R03
            else if (trig_ev && smode == CPCT_SLV_START)
                ctrl[`CPCT_CTRL_EN] <= 1'b1; // R14
            if (bus_wr && paddr == `CPCT_ADDR_MASK)
                mask <= pwdata[`CPCT_STAT_W-1:0];
            if (bus_wr && paddr == `CPCT_ADDR_PSC)
                psc <= pwdata[15:0];
            if (bus_wr && paddr == `CPCT_ADDR_RELOAD)
                reload <= pwdata[15:0];
            if (bus_wr && paddr == `CPCT_ADDR_CHMODE)
                chmode <= pwdata[15:0];
            if (bus_wr && paddr == `CPCT_ADDR_DEADTIME)
                deadtime <= pwdata[7:0];
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ch
            cpct_chmode_t mode;
            logic pol;
            logic cap_ev;
            logic match;
            logic oref;
            logic oref_q;
            logic [7:0] dt_cnt;
            logic out_en;

            assign mode = cpct_chmode_t'(chmode[4*gi +: 2]);
            assign pol = chmode[4*gi+2];
            assign cap_ev = (gi < NCH) && (mode == CPCT_CH_CAPTURE)
                && ((gi == 0 && hall_ev)
                || (pol ? (pin_q[gi] && !pin[gi]) : (!pin_q[gi] && pin[gi]))); // R17
            assign match = (gi < NCH) && step && (mode != CPCT_CH_CAPTURE) && (cnt == ccr[gi]);
            assign ch_set[gi] = cap_ev || match;
            assign out_en = (gi < NCH) && (!IS_ADV || ctrl[`CPCT_CTRL_MOE]) && !(IS_ADV && freeze);

            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    ccr[gi] <= 16'h0000;
                else if (clk_en)
                begin
                    if (cap_ev)
                        ccr[gi] <= cnt; // R17
                    else if (bus_wr && paddr == `CPCT_ADDR_CCR0 + 12'(4 * gi))
                        ccr[gi] <= pwdata[15:0];
                end
            end

            // Reference waveform; a compare above the reload gives fully on, zero fully off.
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    oref <= 1'b0;
                else if (clk_en)
                begin
                    case (mode)
                        CPCT_CH_PWM: oref <= (cnt < ccr[gi]); // R04 R07
                        CPCT_CH_TOGGLE: oref <= match ? !oref : oref; // R03
                        default: oref <= 1'b0;
                    endcase
                end
            end

            // In the advanced variant each change of the reference holds both outputs low for the dead-time.
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    oref_q <= 1'b0;
                    dt_cnt <= 8'h00;
                end
                else if (clk_en)
                begin
                    if (oref != oref_q)
                    begin
                        oref_q <= oref;
                        dt_cnt <= IS_ADV ? deadtime : 8'h00; // R05
                    end
                    else if (dt_cnt != 8'h00)
                        dt_cnt <= dt_cnt - 8'h01;
                end
            end

            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    ch_out[gi] <= 1'b0;
                    ch_out_n[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    ch_out[gi] <= out_en && (dt_cnt == 8'h00) && (oref_q ^ pol); // R08
                    ch_out_n[gi] <= IS_ADV && out_en && chmode[4*gi+3]
                        && (dt_cnt == 8'h00) && (!oref_q ^ pol); // R05 R06
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Status, interrupt, DMA and trigger out
    // ****************************************************************
    logic [`CPCT_STAT_W-1:0] stat_set;
    logic [`CPCT_STAT_W-1:0] stat_clr;

    assign stat_set = {trig_ev, ch_set, wrap};
    assign stat_clr = (bus_wr && paddr == `CPCT_ADDR_STATUS) ? pwdata[`CPCT_STAT_W-1:0] : '0;
    assign irq = |(status & mask);

    // A set in the same cycle as a clear wins.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            status <= '0;
        else if (clk_en)
            status <= (status & ~stat_clr) | stat_set; // R16 R17
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            trig_out <= 1'b0;
            dma_req <= 1'b0;
        end
        else if (clk_en)
        begin
            trig_out <= wrap; // R10 R14 R15
            dma_req <= HAS_DMA && ctrl[`CPCT_CTRL_DMAEN] && (wrap || (|ch_set)); // R11
        end
        else
        begin
            trig_out <= 1'b0;
            dma_req <= 1'b0;
        end
    end

endmodule : cpct_timer

`default_nettype wire

//--- pkg/cpct_cfg.svh
// Register offsets, field positions, reset values and widths of the timer.
// Assumes inclusion by bare name from the timer module, its checker and its bench.
`ifndef CPCT_CFG_SVH
`define CPCT_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CPCT_ADDR_CTRL 12'h000
`define CPCT_ADDR_STATUS 12'h004
`define CPCT_ADDR_MASK 12'h008
`define CPCT_ADDR_PSC 12'h00C
`define CPCT_ADDR_RELOAD 12'h010
`define CPCT_ADDR_COUNT 12'h014
`define CPCT_ADDR_CHMODE 12'h018
`define CPCT_ADDR_DEADTIME 12'h01C
`define CPCT_ADDR_CCR0 12'h020
`define CPCT_ADDR_CCR3 12'h02C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CPCT_CTRL_W 11
`define CPCT_CTRL_EN 0
`define CPCT_CTRL_CMODE 1
`define CPCT_CTRL_ONEPULSE 3
`define CPCT_CTRL_DBGFREEZE 4
`define CPCT_CTRL_SMODE 5
`define CPCT_CTRL_IMODE 7
`define CPCT_CTRL_MOE 9
`define CPCT_CTRL_DMAEN 10

// ****************************************************************
// Status and mask fields
// ****************************************************************
`define CPCT_STAT_W 6
`define CPCT_STAT_UPD 0
`define CPCT_STAT_CH 1
`define CPCT_STAT_TRIG 5

// ****************************************************************
// Reset values
// ****************************************************************
`define CPCT_RST_CTRL 11'h000
`define CPCT_RST_PSC 16'h0000
`define CPCT_RST_RELOAD 16'hFFFF
`define CPCT_RST_CHMODE 16'h0000
`define CPCT_RST_DEADTIME 8'h00

`endif

//--- pkg/cpct_pkg.sv
// Types shared by the timer and its bench.
// Assumes cpct_cfg.svh sits on the include path.
package cpct_pkg;

    // Timer family member selected at build time.
    typedef enum logic [2:0] {
        CPCT_ADVANCED = 3'b000,
        CPCT_FULL_GP = 3'b001,
        CPCT_DUAL_CH = 3'b010,
        CPCT_SINGLE_CH = 3'b011,
        CPCT_BASIC = 3'b100
    } cpct_variant_t;

    typedef enum logic [1:0] {
        CPCT_CNT_UP = 2'b00,
        CPCT_CNT_DOWN = 2'b01,
        CPCT_CNT_CENTER = 2'b10,
        CPCT_CNT_RSVD = 2'b11
    } cpct_cmode_t;

    typedef enum logic [1:0] {
        CPCT_CH_CAPTURE = 2'b00,
        CPCT_CH_TOGGLE = 2'b01,
        CPCT_CH_PWM = 2'b10,
        CPCT_CH_INACTIVE = 2'b11
    } cpct_chmode_t;

    typedef enum logic [1:0] {
        CPCT_SLV_OFF = 2'b00,
        CPCT_SLV_RESET = 2'b01,
        CPCT_SLV_START = 2'b10,
        CPCT_SLV_GATE = 2'b11
    } cpct_smode_t;

    typedef enum logic [1:0] {
        CPCT_IN_INTERNAL = 2'b00,
        CPCT_IN_ENCODER = 2'b01,
        CPCT_IN_HALL = 2'b10,
        CPCT_IN_RSVD = 2'b11
    } cpct_imode_t;

endpackage : cpct_pkg

//--- testbench/cpct_timer_props.sv
// Port assertions for the timer, bound to every timer instance.
// Assumes the register map of cpct_cfg.svh and a mask that resets to zero.
`include "cpct_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cpct_timer_props
import cpct_pkg::*;
#(
    parameter cpct_pkg::cpct_variant_t VARIANT = cpct_pkg::CPCT_ADVANCED
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] ch_in,
    input wire logic trig_in,
    input wire logic dbg_halt,
    input wire logic [3:0] ch_out,
    input wire logic [3:0] ch_out_n,
    input wire logic trig_out,
    input wire logic dma_req,
    input wire logic irq
);
    logic [10:0] ctrl;
    logic [5:0] mask;
    logic wr;
    logic halt;
    assign wr = psel && penable && pwrite && pready && !pslverr;
    assign halt = dbg_halt && ctrl[4] && ctrl[0];

    // Shadow copies of control and mask, taken from completed writes.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= '0;
            mask <= '0;
        end
        else if (wr && paddr == `CPCT_ADDR_CTRL)
            ctrl <= pwdata[10:0];
        else if (wr && paddr == `CPCT_ADDR_MASK)
            mask <= pwdata[5:0];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_COMP_APART: assert property ((ch_out & ch_out_n) == 4'h0)
        else $error("both outputs of a pair high");
    AST_NOUT_ADV: assert property (VARIANT != CPCT_ADVANCED |-> ch_out_n == 4'h0)
        else $error("complementary output outside advanced variant");
    AST_HALT_OFF: assert property (VARIANT == CPCT_ADVANCED && halt [*3]
        |-> ch_out == 4'h0 && ch_out_n == 4'h0)
        else $error("outputs active during debug halt");
    AST_HALT_STOP: assert property (halt [*3] |-> !trig_out)
        else $error("update while counter frozen");
    AST_NO_DMA: assert property ((VARIANT == CPCT_DUAL_CH || VARIANT == CPCT_SINGLE_CH)
        |-> !dma_req)
        else $error("dma request from reduced variant");
    AST_DMA_EN: assert property (dma_req |-> ctrl[10] || $past(ctrl[10]))
        else $error("dma request while disabled");
    AST_BASIC_NOCH: assert property (VARIANT == CPCT_BASIC |-> ch_out == 4'h0)
        else $error("channel output from basic variant");
    AST_UPD_IRQ: assert property (trig_out && mask[0] |-> ##[0:2] irq)
        else $error("unmasked update gave no interrupt");
    AST_IRQ_MASK: assert property (irq |-> mask != 6'h00)
        else $error("interrupt with every source masked");

    cover property (trig_out);
    cover property (dma_req);
    cover property (irq);
    cover property (psel && penable && pslverr);
endmodule : cpct_timer_props

bind cpct_timer cpct_timer_props #(.VARIANT(VARIANT)) cpct_timer_props_inst (.clk_sys(clk_sys),
    .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_in(ch_in), .trig_in(trig_in), .dbg_halt(dbg_halt), .ch_out(ch_out),
    .ch_out_n(ch_out_n), .trig_out(trig_out), .dma_req(dma_req), .irq(irq));
`default_nettype wire

//--- testbench/cpct_peer.sv
// Peer timer and pin model on the far side of the timer.
// Assumes the same clock as the timer; the bench commands triggers and pin levels.
`timescale 1ns/1ns
`default_nettype none
module cpct_peer
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic fire,
    input wire logic [3:0] lag,
    input wire logic [3:0] pins,
    output logic trig_in,
    output logic [3:0] ch_in
);
    logic [3:0] wait_cnt;
    logic armed;

    // A commanded trigger leaves lag + 1 cycles after fire is sampled, as a single-cycle pulse.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            armed <= 1'b0;
            wait_cnt <= 4'h0;
            trig_in <= 1'b0;
        end
        else
        begin
            trig_in <= armed && wait_cnt == 4'h0;
            if (fire)
                armed <= 1'b1;
            else if (wait_cnt == 4'h0)
                armed <= 1'b0;
            wait_cnt <= fire ? lag : (wait_cnt == 4'h0 ? 4'h0 : wait_cnt - 4'h1);
        end
    end

    always_ff @(posedge clk_sys)
        ch_in <= pins;
endmodule : cpct_peer
`default_nettype wire

//--- testbench/cpct_timer_tb.sv
// Self-checking bench for the advanced timer variant over APB.
// Assumes the peer model and the checker are compiled before it.
`include "cpct_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cpct_timer_tb;
import cpct_pkg::*;
    logic clk_sys, resetn, clk_en, psel, penable, pwrite, dbg_halt, fire, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, x;
    logic [3:0] pins, lag;
    wire logic pready, pslverr, trig_in, trig_out, dma_req, irq;
    wire logic [31:0] prdata;
    wire logic [3:0] ch_in, ch_out, ch_out_n;
    int failures, check_count, n, p, r, g, ho, hn;
    int tab[4][5] = '{'{0, 0, 100, 0, 100}, '{0, 5, 100, 30, 30}, '{0, 10, 100, 100, 0},
        '{2, 5, 90, 35, 35}};

    cpct_timer cpct_timer_inst (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .trig_in(trig_in),
        .dbg_halt(dbg_halt), .ch_out(ch_out), .ch_out_n(ch_out_n), .trig_out(trig_out),
        .dma_req(dma_req), .irq(irq));
    cpct_peer cpct_peer_inst (.clk_sys(clk_sys), .resetn(resetn), .fire(fire), .lag(lag),
        .pins(pins), .trig_in(trig_in), .ch_in(ch_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        check_count++;
        if (got !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, e, rd);
    endtask : rdchk

    initial
    begin
        repeat (30000) @(posedge clk_sys);
        failures++;
        final_report();
    end

    initial
    begin
        {resetn, clk_en, psel, penable, pwrite, dbg_halt, fire, pins, lag} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        clk_en = 1'b1;
        n = $urandom(32'hF13AB733);
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rdchk(`CPCT_ADDR_CTRL, 32'h0, "ctrl reset");
        rdchk(`CPCT_ADDR_PSC, 32'h0, "psc reset");
        rdchk(`CPCT_ADDR_RELOAD, 32'hFFFF, "reload reset");
        rdchk(`CPCT_ADDR_DEADTIME, 32'h0, "deadtime reset");
        apb(1'b1, 12'h100, 32'hFFFFFFFF);
        chk("unmapped error", 32'h1, err);
        p = $urandom_range(3);
        r = $urandom_range(9, 3);
        apb(1'b1, `CPCT_ADDR_PSC, p);
        rdchk(`CPCT_ADDR_PSC, p, "psc");
        apb(1'b1, `CPCT_ADDR_RELOAD, r);
        for (n = 0; n < 3; n++)
        begin
            apb(1'b1, `CPCT_ADDR_CTRL, 32'h0);
            apb(1'b1, `CPCT_ADDR_COUNT, 32'h0);
            apb(1'b1, `CPCT_ADDR_CTRL, 32'h1 | n << 1);
            while (trig_out !== 1'b1)
                @(posedge clk_sys);
            g = 0;
            do
            begin
                @(posedge clk_sys);
                g++;
            end
            while (trig_out !== 1'b1 && g < 3000);
            chk("update period", (n == 2 ? r : r + 1) * (p + 1), g);
        end
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h0);
        rdchk(`CPCT_ADDR_STATUS, 32'h1, "update flag");
        chk("masked irq", 32'h0, irq);
        apb(1'b1, `CPCT_ADDR_MASK, 32'h1);
        chk("unmasked irq", 32'h1, irq);
        apb(1'b1, `CPCT_ADDR_STATUS, 32'h1);
        chk("cleared irq", 32'h0, irq);
        apb(1'b1, `CPCT_ADDR_PSC, 32'h0);
        apb(1'b1, `CPCT_ADDR_RELOAD, 32'h9);
        apb(1'b1, `CPCT_ADDR_DEADTIME, 32'h2);
        apb(1'b1, `CPCT_ADDR_CHMODE, 32'hA);
        for (n = 0; n < 4; n++)
        begin
            apb(1'b1, `CPCT_ADDR_CCR0, tab[n][1]);
            apb(1'b1, `CPCT_ADDR_CTRL, 32'h201 | tab[n][0] << 1);
            repeat (40) @(posedge clk_sys);
            ho = 0;
            hn = 0;
            repeat (tab[n][2])
            begin
                @(posedge clk_sys);
                ho += ch_out[0];
                hn += ch_out_n[0];
            end
            chk("pwm high", tab[n][3], ho);
            chk("pwm low side", tab[n][4], hn);
        end
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h215);
        dbg_halt <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("halt outputs", 32'h0, {ch_out, ch_out_n});
        apb(1'b0, `CPCT_ADDR_COUNT, 32'h0);
        x = rd;
        rdchk(`CPCT_ADDR_COUNT, x, "frozen count");
        dbg_halt <= 1'b0;
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h0);
        apb(1'b1, `CPCT_ADDR_CHMODE, 32'h0);
        x = $urandom_range(16'hFFFF, 16'h0100);
        apb(1'b1, `CPCT_ADDR_COUNT, x);
        apb(1'b1, `CPCT_ADDR_STATUS, 32'h3F);
        pins <= 4'h1;
        repeat (10) @(posedge clk_sys);
        rdchk(`CPCT_ADDR_CCR0, x, "capture value");
        rdchk(`CPCT_ADDR_STATUS, 32'h2, "capture flag");
        pins <= 4'h0;
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h40);
        lag <= 4'($urandom_range(7));
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (30) @(posedge clk_sys);
        apb(1'b0, `CPCT_ADDR_COUNT, 32'h0);
        chk("started by trigger", 32'h1, rd !== x);
        apb(1'b0, `CPCT_ADDR_STATUS, 32'h0);
        chk("trigger flag", 32'h1, rd[5]);
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h409);
        g = 0;
        while (dma_req !== 1'b1 && g < 200)
        begin
            @(posedge clk_sys);
            g++;
        end
        chk("dma request", 32'h1, dma_req);
        rdchk(`CPCT_ADDR_CTRL, 32'h408, "one pulse stop");
        apb(1'b1, `CPCT_ADDR_CTRL, 32'h81);
        for (n = 1; n < 5; n++)
        begin
            pins <= 4'((n & 3) ^ (n & 3) >> 1);
            repeat (8) @(posedge clk_sys);
        end
        rdchk(`CPCT_ADDR_COUNT, 32'h4, "encoder count");
        final_report();
    end
endmodule : cpct_timer_tb
`default_nettype wire
